// ### rtl/ecc_pkg.sv
// Register map, field layout and types of the event counter control block
package ecc_pkg;
    localparam int unsigned ADDR_W = 12;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL = 10'h100;
    localparam logic [9:0] IDX_IOC  = 10'h101;
    localparam logic [9:0] IDX_MODE = 10'h102;
    localparam logic [9:0] IDX_PRE  = 10'h103;
    localparam logic [9:0] IDX_MAIN = 10'h104;
    localparam logic [9:0] IDX_IST  = 10'h105;
    localparam logic [9:0] IDX_IMSK = 10'h106;
    localparam logic [9:0] IDX_PORT = 10'h107;
    // Control register bits
    localparam int unsigned B_EN   = 0;
    localparam int unsigned B_RUN  = 1;
    localparam int unsigned B_STOP = 2;
    localparam int unsigned B_EDGF = 4;
    localparam int unsigned B_UNDF = 5;
    // Mode values and fields
    localparam logic [2:0] MODE_EVENT = 3'h2;
    localparam logic [7:0] MODE_KEEP  = 8'hf7;
    localparam logic [7:0] CTRL_KEEP  = 8'h30;
    localparam logic [7:0] CNT_FULL   = 8'hff;
    localparam logic [7:0] RST_BYTE   = 8'h00;
    // Filter sampling dividers
    localparam logic [1:0] FILT_OFF  = 2'h0;
    localparam logic [1:0] FILT_F1   = 2'h1;
    localparam logic [1:0] FILT_F8   = 2'h2;
    localparam logic [4:0] DIV_F8    = 5'h07;
    localparam logic [4:0] DIV_F32   = 5'h1f;
    // Interrupt status bits
    localparam int unsigned IRQ_UNDER = 0;
    localparam int unsigned IRQ_EDGE  = 1;
    localparam int unsigned IRQ_N     = 2;

    // I/O control register layout
    typedef struct packed {
        logic       rsvd;
        logic       rsvd2;
        logic [1:0] filt_sel;
        logic       pin_sel;
        logic       pulse_oe;
        logic       io_out_ctl;
        logic       edge_pol;
    } ecc_ioc_t;

    // Pending write of a counter during counting
    typedef enum logic [1:0] {WR_IDLE, WR_PEND, WR_XFER} ecc_wr_t;
endpackage

// ### rtl/ecc_top.sv
// Event counter control: registers, input select and filter, counters, pulse out
//
// Summary of operation
// RULE1: Mode write resets pulse pin to start level
// RULE2: Enable bit runs counter; clear halts
// RULE3: Read-only flag shows counting in progress
// RULE4: Forced stop halts at once, reads zero
// RULE5: Unassigned control bits read zero
// RULE6: Software keeps edge judgment flag zero
// RULE7: Software keeps underflow flag zero
// RULE8: Polarity zero: rising edges, output starts low
// RULE9: Software keeps output control bit zero
// RULE10: Output enable picks port data or pulse
// RULE11: Select bit routes one of two pins
// RULE12: Two-bit field sets filter and sample rate
// RULE13: Prescaler then timer decrement, reload on underflow
// RULE14: Forced stop loads both counters with FFh
// RULE15: Mode field 010 selects event counting
// RULE16: Counting writes reach counter over two edges
// RULE17: Status flag ignores writes, follows internal state
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/10ps
module ecc_top #(
    parameter int unsigned SYNC_N = 3
) (
    input  wire logic                       clock,
    input  wire logic                       reset,
    input  wire logic [ecc_pkg::ADDR_W-1:0] address,
    input  wire logic                       read,
    input  wire logic                       write,
    input  wire logic [31:0]                writedata,
    output logic [31:0]                     readdata,
    output logic                            waitrequest,
    input  wire logic                       count_pin_a,
    input  wire logic                       count_pin_b,
    output logic                            pulse_output_pin,
    output logic                            irq
);
    // Register index decode, shared by read and write paths
    function automatic logic hit(input logic [ecc_pkg::ADDR_W-1:0] a,
                                 input logic [9:0] idx);
        hit = (a[ecc_pkg::ADDR_W-1:2] == idx);
    endfunction

    logic                 wait_q;
    logic [31:0]          rdata_q;
    logic                 en_q;
    logic                 run_q;
    logic [7:0]           ctrl_keep_q;
    ecc_pkg::ecc_ioc_t    ioc_q;
    logic [7:0]           mode_q;
    logic [7:0]           pre_q;
    logic [7:0]           pre_rl_q;
    logic [7:0]           main_q;
    logic [7:0]           main_rl_q;
    logic [7:0]           pre_new_q;
    logic [7:0]           main_new_q;
    logic                 pre_wr_q;
    logic                 main_wr_q;
    ecc_pkg::ecc_wr_t     wr_q;
    logic [ecc_pkg::IRQ_N-1:0] ist_q;
    logic [ecc_pkg::IRQ_N-1:0] imsk_q;
    logic                 port_q;
    logic                 pulse_q;
    logic                 pin_q;
    logic                 irq_q;
    logic [SYNC_N-1:0]    sync_a_q;
    logic [SYNC_N-1:0]    sync_b_q;
    logic                 lvl_a_q;
    logic                 lvl_b_q;
    logic [4:0]           div_q;
    logic [2:0]           samp_q;
    logic                 filt_q;
    logic                 prev_q;

    // Bus handshake: one wait state, then the access completes
    wire acc   = read | write;
    wire done  = acc & ~wait_q;
    wire wr_en = write & ~wait_q;
    wire w_ctl = wr_en & hit(address, ecc_pkg::IDX_CTRL);
    wire w_ioc = wr_en & hit(address, ecc_pkg::IDX_IOC);
    wire w_mod = wr_en & hit(address, ecc_pkg::IDX_MODE);
    wire w_pre = wr_en & hit(address, ecc_pkg::IDX_PRE);
    wire w_man = wr_en & hit(address, ecc_pkg::IDX_MAIN);
    wire w_ist = wr_en & hit(address, ecc_pkg::IDX_IST);
    wire w_msk = wr_en & hit(address, ecc_pkg::IDX_IMSK);
    wire w_prt = wr_en & hit(address, ecc_pkg::IDX_PORT);
    wire [7:0] wd = writedata[7:0];

    // Forced stop has priority over a simultaneous start
    wire fstop   = w_ctl & wd[ecc_pkg::B_STOP];                          // RULE4
    wire ev_mode = (mode_q[2:0] == ecc_pkg::MODE_EVENT);                 // RULE15
    wire counting = run_q & ev_mode;

    // Read mux; unassigned bits and unmapped addresses read zero
    wire [7:0] ctrl_rd = (ctrl_keep_q & ecc_pkg::CTRL_KEEP)
                       | {6'h00, counting, en_q};                        // RULE3 RULE5
    wire [7:0] rd_mux =
        hit(address, ecc_pkg::IDX_CTRL) ? ctrl_rd :
        hit(address, ecc_pkg::IDX_IOC)  ? {2'h0, ioc_q[5:0]} :
        hit(address, ecc_pkg::IDX_MODE) ? (mode_q & ecc_pkg::MODE_KEEP) :
        hit(address, ecc_pkg::IDX_PRE)  ? pre_q :
        hit(address, ecc_pkg::IDX_MAIN) ? main_q :
        hit(address, ecc_pkg::IDX_IST)  ? {6'h00, ist_q} :
        hit(address, ecc_pkg::IDX_IMSK) ? {6'h00, imsk_q} :
        hit(address, ecc_pkg::IDX_PORT) ? {7'h00, port_q} : ecc_pkg::RST_BYTE;

    // Pin select before filtering; only settled sync levels are used
    wire pin_lvl = ioc_q.pin_sel ? lvl_b_q : lvl_a_q;                    // RULE11
    wire samp_en = (ioc_q.filt_sel == ecc_pkg::FILT_F1)
                 | ((ioc_q.filt_sel == ecc_pkg::FILT_F8) ? (div_q[2:0] == ecc_pkg::DIV_F8[2:0])
                                                         : (div_q == ecc_pkg::DIV_F32));
    wire filt_on = (ioc_q.filt_sel != ecc_pkg::FILT_OFF);                // RULE12
    wire agree   = (samp_q == 3'h7) | (samp_q == 3'h0);
    wire in_lvl  = filt_on ? filt_q : pin_lvl;

    // Active edge: rising when polarity is zero, falling otherwise
    wire rise  = in_lvl & ~prev_q;
    wire fall  = ~in_lvl & prev_q;
    wire edge_ev = counting & (ioc_q.edge_pol ? fall : rise);            // RULE8

    // Decrement chain; timer steps only on prescaler underflow
    wire step    = edge_ev & (wr_q == ecc_pkg::WR_IDLE);
    wire pre_uf  = step & (pre_q == 8'h00);                              // RULE13
    wire main_uf = pre_uf & (main_q == 8'h00);
    wire [7:0] pre_dec  = pre_q - 8'h01;
    wire [7:0] main_dec = main_q - 8'h01;
    wire [ecc_pkg::IRQ_N-1:0] ev_set = {edge_ev, main_uf};

    // Bus handshake and read data capture
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            wait_q  <= ~(acc & wait_q);
            rdata_q <= {24'h00_0000, rd_mux};
        end
    end

    // Control register; running flag is never written by software
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            en_q        <= 1'b0;
            run_q       <= 1'b0;
            ctrl_keep_q <= ecc_pkg::RST_BYTE;
        end
        else
        begin
            if (fstop)
                en_q <= 1'b0;                                            // RULE4
            else if (w_ctl)
                en_q <= wd[ecc_pkg::B_EN];                               // RULE2
            if (w_ctl)
                ctrl_keep_q <= wd;                                       // RULE6 RULE7
            run_q <= en_q & ~fstop;                                      // RULE3 RULE17
        end
    end

    // Configuration registers
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            ioc_q  <= '0;
            mode_q <= ecc_pkg::RST_BYTE;
            imsk_q <= '0;
            port_q <= 1'b0;
        end
        else
        begin
            if (w_ioc)
                ioc_q <= ecc_pkg::ecc_ioc_t'(wd);                        // RULE9
            if (w_mod)
                mode_q <= wd;
            if (w_msk)
                imsk_q <= wd[ecc_pkg::IRQ_N-1:0];
            if (w_prt)
                port_q <= wd[0];
        end
    end

    // Three-stage synchronisers; level moves when stages two and three agree
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            sync_a_q <= '0;
            sync_b_q <= '0;
            lvl_a_q  <= 1'b0;
            lvl_b_q  <= 1'b0;
        end
        else
        begin
            sync_a_q <= {sync_a_q[SYNC_N-2:0], count_pin_a};
            sync_b_q <= {sync_b_q[SYNC_N-2:0], count_pin_b};
            if (sync_a_q[SYNC_N-1] == sync_a_q[SYNC_N-2])
                lvl_a_q <= sync_a_q[SYNC_N-1];
            if (sync_b_q[SYNC_N-1] == sync_b_q[SYNC_N-2])
                lvl_b_q <= sync_b_q[SYNC_N-1];
        end
    end

    // Digital filter: three equal samples at the chosen rate
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            div_q  <= 5'h00;
            samp_q <= 3'h0;
            filt_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            div_q  <= div_q + 5'h01;
            prev_q <= in_lvl;
            if (samp_en)
                samp_q <= {samp_q[1:0], pin_lvl};                        // RULE12
            if (agree)
                filt_q <= samp_q[0];
        end
    end

    // Counters, reloads and the deferred write path
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pre_q      <= ecc_pkg::CNT_FULL;
            pre_rl_q   <= ecc_pkg::CNT_FULL;
            main_q     <= ecc_pkg::CNT_FULL;
            main_rl_q  <= ecc_pkg::CNT_FULL;
            pre_new_q  <= ecc_pkg::CNT_FULL;
            main_new_q <= ecc_pkg::CNT_FULL;
            pre_wr_q   <= 1'b0;
            main_wr_q  <= 1'b0;
            wr_q       <= ecc_pkg::WR_IDLE;
        end
        else if (fstop)
        begin
            pre_q  <= ecc_pkg::CNT_FULL;                                 // RULE14
            main_q <= ecc_pkg::CNT_FULL;
            pre_wr_q  <= 1'b0;
            main_wr_q <= 1'b0;
            wr_q   <= ecc_pkg::WR_IDLE;
        end
        else if ((w_pre | w_man) & counting)
        begin
            if (w_pre)
            begin
                pre_new_q <= wd;                                         // RULE16
                pre_wr_q  <= 1'b1;
            end
            if (w_man)
            begin
                main_new_q <= wd;
                main_wr_q  <= 1'b1;
            end
            wr_q <= ecc_pkg::WR_PEND;
        end
        else if (w_pre | w_man)
        begin
            if (w_pre)
            begin
                pre_q    <= wd;
                pre_rl_q <= wd;
            end
            if (w_man)
            begin
                main_q    <= wd;
                main_rl_q <= wd;
            end
        end
        else if (edge_ev)
        begin
            case (wr_q)
                ecc_pkg::WR_PEND:
                begin
                    if (pre_wr_q)
                        pre_rl_q <= pre_new_q;                           // RULE16
                    if (main_wr_q)
                        main_rl_q <= main_new_q;
                    wr_q <= ecc_pkg::WR_XFER;
                end
                ecc_pkg::WR_XFER:
                begin
                    pre_q     <= pre_rl_q;
                    main_q    <= main_rl_q;
                    pre_wr_q  <= 1'b0;
                    main_wr_q <= 1'b0;
                    wr_q      <= ecc_pkg::WR_IDLE;
                end
                default:
                begin
                    pre_q <= pre_uf ? pre_rl_q : pre_dec;                // RULE13
                    if (pre_uf)
                        main_q <= main_uf ? main_rl_q : main_dec;
                end
            endcase
        end
    end

    // Pulse output inverts on underflow; mode write restores start level
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pulse_q <= 1'b0;
            pin_q   <= 1'b0;
        end
        else
        begin
            if (w_mod)
                pulse_q <= ioc_q.edge_pol;                               // RULE1 RULE8
            else if (main_uf)
                pulse_q <= ~pulse_q;
            pin_q <= ioc_q.pulse_oe ? pulse_q : port_q;                  // RULE10
        end
    end

    // Sticky interrupt status; a new event beats a same-cycle clear
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            ist_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            ist_q <= (ist_q & ~(w_ist ? wd[ecc_pkg::IRQ_N-1:0] : '0)) | ev_set;
            irq_q <= |(ist_q & imsk_q);
        end
    end

    assign readdata         = rdata_q;
    assign waitrequest      = wait_q;
    assign pulse_output_pin = pin_q;
    assign irq              = irq_q;
endmodule

// ### verif/ecc_asserts.sv
// Port-level checker for the event counter control block
`timescale 1ns/10ps
module ecc_asserts (
    input wire logic                       clock,
    input wire logic                       reset,
    input wire logic [ecc_pkg::ADDR_W-1:0] address,
    input wire logic                       read,
    input wire logic                       write,
    input wire logic [31:0]                writedata,
    input wire logic [31:0]                readdata,
    input wire logic                       waitrequest,
    input wire logic                       count_pin_a,
    input wire logic                       count_pin_b,
    input wire logic                       pulse_output_pin,
    input wire logic                       irq
);
    // Access decode, taken only at the completing edge
    wire logic [9:0] idx  = address[ecc_pkg::ADDR_W-1:2];
    wire logic       wr_c = write && !waitrequest && idx == ecc_pkg::IDX_CTRL;
    wire logic       rd_c = read && !waitrequest && idx == ecc_pkg::IDX_CTRL;
    wire logic       wr_m = write && !waitrequest && idx == ecc_pkg::IDX_MODE;
    wire logic       wr_i = write && !waitrequest && idx == ecc_pkg::IDX_IOC;
    wire logic       wr_p = write && !waitrequest && idx == ecc_pkg::IDX_PORT;
    logic            en_q;
    logic            ev_q;
    logic            oe_q;
    logic            pol_q;
    logic            port_q;

    // Shadow of what software last wrote; counters are not modelled here
    always_ff @(posedge clock or posedge reset)
        if (reset)
            {en_q, ev_q, oe_q, pol_q, port_q} <= 5'h00;
        else
        begin
            if (wr_c) en_q <= writedata[0] && !writedata[2];
            if (wr_m) ev_q <= writedata[2:0] == ecc_pkg::MODE_EVENT;
            if (wr_i) {oe_q, pol_q} <= {writedata[2], writedata[0]};
            if (wr_p) port_q <= writedata[0];
        end

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // One wait state, then waitrequest back up
    sequence done_s;
        !waitrequest ##1 waitrequest;
    endsequence

    bus_wait_a: assert property ((read || write) && waitrequest |=> done_s)
        else $error("access not answered after one wait state");
    upper_zero_a: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    ctrl_rsvd_a: assert property (rd_c |-> readdata[7:6] == 2'h0 && !readdata[3])
        else $error("unassigned control bits not zero");
    stop_zero_a: assert property (rd_c |-> !readdata[ecc_pkg::B_STOP])
        else $error("forced stop bit reads one");
    enable_read_a: assert property (rd_c |-> readdata[ecc_pkg::B_EN] == en_q)
        else $error("enable bit readback wrong");
    run_flag_a: assert property (rd_c |-> readdata[ecc_pkg::B_RUN] == (en_q && ev_q))
        else $error("running flag wrong");
    mode_level_a: assert property (wr_m && oe_q |-> ##2 pulse_output_pin == pol_q)
        else $error("pulse pin not at start level after mode write");
    port_pin_a: assert property (wr_p && !oe_q |-> ##2 pulse_output_pin == port_q)
        else $error("pin does not follow port data");
endmodule

bind ecc_top ecc_asserts u_chk (.clock(clock), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .count_pin_a(count_pin_a), .count_pin_b(count_pin_b),
    .pulse_output_pin(pulse_output_pin), .irq(irq));

// ### verif/ecc_pin_model.sv
// External event source on the two count input pins
`timescale 1ns/10ps
module ecc_pin_model (
    input  wire logic clock,
    output logic      pin_a,
    output logic      pin_b
);
    logic sel_q = 1'b0;
    logic lvl_q = 1'b0;
    logic tog_q = 1'b0;

    // Idle pin chatters each cycle, so a wrong select can never settle
    always @(posedge clock)
        tog_q <= ~tog_q;
    assign pin_a = sel_q ? tog_q : lvl_q;
    assign pin_b = sel_q ? lvl_q : tog_q;

    // n rising edges; each level held h cycles, which decides whether the filter passes it
    task automatic pulse(input int n, input int h, input logic s);
        @(posedge clock);
        sel_q <= s;
        repeat (n)
        begin
            repeat (h) @(posedge clock);
            lvl_q <= 1'b1;
            repeat (h) @(posedge clock);
            lvl_q <= 1'b0;
        end
        repeat (h) @(posedge clock);
    endtask
endmodule

// ### verif/tb_top.sv
// Register-level testbench for the event counter control block
`timescale 1ns/10ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module tb_top;
    logic                       clock;
    logic                       reset;
    logic [ecc_pkg::ADDR_W-1:0] address;
    logic                       read;
    logic                       write;
    logic [31:0]                writedata;
    logic [31:0]                readdata;
    logic                       waitrequest;
    logic                       count_pin_a;
    logic                       count_pin_b;
    logic                       pulse_output_pin;
    logic                       irq;
    int                         err_count;
    int                         num_checks;
    int                         cyc;

    ecc_top u_dut (.clock(clock), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .count_pin_a(count_pin_a), .count_pin_b(count_pin_b),
        .pulse_output_pin(pulse_output_pin), .irq(irq));
    ecc_pin_model u_pin (.clock(clock), .pin_a(count_pin_a), .pin_b(count_pin_b));

    // Free-running clock, 4 ns period
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Hang guard; the whole run needs about 1200 cycles
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            conclude;
        end
    end

    // One bus access; held until waitrequest is sampled low at a rising edge
    task automatic acc(input logic w, input logic [9:0] i, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clock);
        read      <= !w;
        write     <= w;
        address   <= {i, 2'h0};
        writedata <= {24'h0, d};
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, i, d, q);
    endtask

    task automatic rc(input string n, input logic [9:0] i, input logic [7:0] e);
        logic [7:0] q;
        acc(1'b0, i, 8'h00, q);
        `CHK(n, e, q)
    endtask

    // Outputs lag the write by two clocks
    task automatic out_chk(input logic ep, input logic ei);
        repeat (3) @(negedge clock);
        `CHK("pin", ep, pulse_output_pin)
        `CHK("irq", ei, irq)
    endtask

    initial
    begin
        reset     = 1'b1;
        read      = 1'b0;
        write     = 1'b0;
        address   = '0;
        writedata = 32'h0;
        err_count = 0;
        num_checks = 0;
        cyc       = 0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        rc("ctrl", ecc_pkg::IDX_CTRL, 8'h00);
        rc("ioc", ecc_pkg::IDX_IOC, 8'h00);
        rc("main", ecc_pkg::IDX_MAIN, 8'hff);
        rc("none", 10'h1ff, 8'h00);
        wr(ecc_pkg::IDX_IOC, 8'h3d);
        rc("ioc", ecc_pkg::IDX_IOC, 8'h3d);
        wr(ecc_pkg::IDX_MODE, 8'h02);
        out_chk(1'b1, 1'b0);
        wr(ecc_pkg::IDX_IOC, 8'h04);
        wr(ecc_pkg::IDX_MODE, 8'h02);
        out_chk(1'b0, 1'b0);
        rc("mode", ecc_pkg::IDX_MODE, 8'h02);
        wr(ecc_pkg::IDX_IOC, 8'h00);
        wr(ecc_pkg::IDX_PORT, 8'h01);
        out_chk(1'b1, 1'b0);
        wr(ecc_pkg::IDX_IOC, 8'h04);
        out_chk(1'b0, 1'b0);
        wr(ecc_pkg::IDX_CTRL, 8'h02);
        rc("ctrl", ecc_pkg::IDX_CTRL, 8'h00);
        // Divide by (1+1)*(2+1): six edges per underflow
        wr(ecc_pkg::IDX_PRE, 8'h01);
        wr(ecc_pkg::IDX_MAIN, 8'h02);
        wr(ecc_pkg::IDX_CTRL, 8'h01);
        rc("ctrl", ecc_pkg::IDX_CTRL, 8'h03);
        u_pin.pulse(2, 10, 1'b0);
        rc("pre", ecc_pkg::IDX_PRE, 8'h01);
        rc("main", ecc_pkg::IDX_MAIN, 8'h01);
        u_pin.pulse(4, 10, 1'b0);
        rc("main", ecc_pkg::IDX_MAIN, 8'h02);
        out_chk(1'b1, 1'b0);
        rc("stat", ecc_pkg::IDX_IST, 8'h03);
        wr(ecc_pkg::IDX_IMSK, 8'h01);
        out_chk(1'b1, 1'b1);
        wr(ecc_pkg::IDX_IST, 8'h01);
        out_chk(1'b1, 1'b0);
        rc("stat", ecc_pkg::IDX_IST, 8'h02);
        // Write while counting lands over two edges, counts on the third
        wr(ecc_pkg::IDX_PRE, 8'h05);
        u_pin.pulse(2, 10, 1'b0);
        rc("pre", ecc_pkg::IDX_PRE, 8'h05);
        u_pin.pulse(1, 10, 1'b0);
        rc("pre", ecc_pkg::IDX_PRE, 8'h04);
        wr(ecc_pkg::IDX_CTRL, 8'h00);
        u_pin.pulse(2, 10, 1'b0);
        rc("pre", ecc_pkg::IDX_PRE, 8'h04);
        wr(ecc_pkg::IDX_CTRL, 8'h01);
        wr(ecc_pkg::IDX_CTRL, 8'h04);
        rc("ctrl", ecc_pkg::IDX_CTRL, 8'h00);
        rc("pre", ecc_pkg::IDX_PRE, 8'hff);
        rc("main", ecc_pkg::IDX_MAIN, 8'hff);
        u_pin.pulse(1, 10, 1'b0);
        rc("pre", ecc_pkg::IDX_PRE, 8'hff);
        // Second pin, slowest filter: short pulse rejected, long one counted
        wr(ecc_pkg::IDX_IOC, 8'h3c);
        wr(ecc_pkg::IDX_CTRL, 8'h01);
        u_pin.pulse(1, 4, 1'b1);
        rc("pre", ecc_pkg::IDX_PRE, 8'hff);
        u_pin.pulse(1, 120, 1'b1);
        rc("pre", ecc_pkg::IDX_PRE, 8'hfe);
        // Leaving event mode: enable stays set, but nothing counts
        wr(ecc_pkg::IDX_MODE, 8'h00);
        rc("ctrl", ecc_pkg::IDX_CTRL, 8'h01);
        u_pin.pulse(1, 120, 1'b1);
        rc("pre", ecc_pkg::IDX_PRE, 8'hfe);
        conclude;
    end
endmodule
